// [logic/isp_sec_pkg.sv]
// Purpose: shared constants and types for the test-port security block
// Assumes: 32-bit AHB-Lite register bus, byte-wide flash image
// Notes:   timing counts are defaults; the top module exposes them as parameters
package isp_sec_pkg;
    // command frame shifted in over the serial port
    localparam int CMD_W    = 24;
    localparam int OP_LSB   = 20;
    localparam int ADDR_LSB = 8;
    localparam int DATA_LSB = 0;
    localparam int ADDR_W   = 6;
    localparam int DATA_W   = 8;

    // flash image: 8 primary + 4 secondary sectors
    localparam int NUM_SECTORS  = 12;
    localparam int SECTOR_BYTES = 4;
    localparam int SECTOR_W     = 4;

    // serial port opcodes
    localparam logic [3:0] OP_NOP          = 4'h0;
    localparam logic [3:0] OP_READ         = 4'h1;
    localparam logic [3:0] OP_PROGRAM      = 4'h2;
    localparam logic [3:0] OP_SECTOR_ERASE = 4'h3;
    localparam logic [3:0] OP_CHIP_ERASE   = 4'h4;
    localparam logic [3:0] OP_VERIFY       = 4'h5;
    localparam logic [3:0] OP_CLEAR        = 4'h6;

    // register offsets (byte addresses)
    localparam logic [11:0] PORT_ENABLE_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS      = 12'h004;
    localparam logic [11:0] CONFIG_OFS      = 12'h008;

    // reset and delivered values
    localparam logic [7:0] PORT_ENABLE_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST      = 8'h00;
    localparam logic [7:0] ERASED_BYTE     = 8'hFF;

    // field positions
    localparam int ENABLE_BIT = 0;
    localparam int SB_LOCK    = 0;
    localparam int SB_PORT    = 1;
    localparam int SB_BUSY    = 2;
    localparam int SB_ERR     = 3;
    localparam int SB_DEDIC   = 4;
    localparam int SB_LOADED  = 5;

    // busy time of flash operations, in hclk cycles
    localparam int ERASE_CYCLES_DEF   = 16;
    localparam int PROGRAM_CYCLES_DEF = 4;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } test_pins_t;

    typedef struct packed {
        logic                   secure;
        logic                   dedicate;
        logic [NUM_SECTORS-1:0] sector_protect;
    } nv_config_t;

    typedef enum logic [1:0] {
        OPS_IDLE = 2'b00,
        OPS_BUSY = 2'b01,
        OPS_DONE = 2'b11
    } op_state_t;
endpackage

// [logic/link_sampler.sv]
// Purpose: two-flop synchroniser with rise detect for slow pins
// Assumes: inputs are quasi-static or much slower than hclk
// Notes:   edge detect reads only the second stage and beyond
`timescale 1ns/100ps
module link_sampler #(
    parameter int WIDTH = 1
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] pins,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] prev_reg;

    // two stages then one history stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~prev_reg;
endmodule

// [logic/flash_image.sv]
// Purpose: byte array standing for primary and secondary flash
// Assumes: program only clears bits, erase sets a sector to blank
// Notes:   reset returns the blank delivered image
`timescale 1ns/100ps
module flash_image
    import isp_sec_pkg::*;
#(
    parameter int SECTORS = NUM_SECTORS,
    parameter int BYTES   = SECTOR_BYTES
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              prog_en,
    input  wire logic              sect_erase_en,
    input  wire logic              chip_erase_en,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem_reg [SECTORS*BYTES];

    // blank delivered state reads all ones; program ands bits in
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < SECTORS*BYTES; i++) mem_reg[i] <= ERASED_BYTE;
        end else begin
            for (int i = 0; i < SECTORS*BYTES; i++) begin
                if (chip_erase_en || (sect_erase_en && (i / BYTES) == (int'(addr) / BYTES)))
                    mem_reg[i] <= ERASED_BYTE;
                else if (prog_en && i == int'(addr))
                    mem_reg[i] <= mem_reg[i] & wdata;
            end
        end
    end

    assign rdata = (int'(addr) < SECTORS*BYTES) ? mem_reg[addr] : ERASED_BYTE;
endmodule

// [logic/jtag_isp_security_control.sv]
// Purpose: serial test port access control with security lock
// Assumes: nv config static once config_loaded rises; tck slow vs hclk
// Notes:   frame shifts on tck rise with tms low, runs on tck rise with tms high
// Functional notes
// - locked part refuses all memory readout
// - locked port accepts only full-chip erase and error clear
// - locked port blocks other program/erase/verify
// - full-chip erase clears lock, leaves part blank
// - protected sector refuses erase
// - delivered memory reads all ones
// - delivered configuration bits read zero
// - enable bit 0 switches port on/off
// - dedicated pins ignore chip reset
// - register-enabled port aborted by chip reset
// - port on if dedicate, or if register or term while chip reset is inactive
// - chip reset clears run-time enable bit
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
module jtag_isp_security_control #(
    parameter int ERASE_CYCLES   = isp_sec_pkg::ERASE_CYCLES_DEF,
    parameter int PROGRAM_CYCLES = isp_sec_pkg::PROGRAM_CYCLES_DEF
) (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     hsel,
    input  wire logic [11:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic                          hreadyout,
    output logic      [31:0]              hrdata,
    output logic                          hresp,
    input  wire isp_sec_pkg::test_pins_t  test_pins,
    input  wire logic                     chip_reset_n,
    input  wire logic                     config_loaded,
    input  wire isp_sec_pkg::nv_config_t  nv_config,
    input  wire logic                     pin_enable_product_term,
    output logic                          tdo_out,
    output logic                          tdo_oe_n,
    output logic                          program_status_out,
    output logic                          program_error_out_n,
    output logic                          port_active
);
    import isp_sec_pkg::*;

    logic [5:0]        pin_level;
    logic [5:0]        pin_rise;
    logic              tck_rise;
    logic              tms_lvl;
    logic              tdi_lvl;
    logic              chip_rst;
    logic              loaded_lvl;
    logic              term_lvl;
    logic              loaded_reg;
    logic              lock_reg;
    logic              dedic_reg;
    logic [NUM_SECTORS-1:0] protect_reg;
    logic              enable_reg;
    logic [7:0]        config_reg;
    logic              wr_pend_reg;
    logic [11:0]       wr_addr_reg;
    logic [CMD_W-1:0]  shift_reg;
    logic              err_reg;
    op_state_t         state_reg;
    logic [15:0]       count_reg;
    logic [3:0]        op_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] data_reg;
    logic [DATA_W-1:0] flash_rdata;
    logic              execute;
    logic [3:0]        cmd_op;
    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] cmd_data;
    logic              port_on;
    logic              abort;
    logic              allowed;
    logic              prot_hit;
    logic              start_op;
    logic              finish;

    // sector index of a byte address
    function automatic logic [SECTOR_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
        sector_of = SECTOR_W'(int'(a) / SECTOR_BYTES);
    endfunction

    link_sampler #(.WIDTH(6)) u_sampler (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pins    ({pin_enable_product_term, config_loaded, ~chip_reset_n,
                   test_pins.tck, test_pins.tms, test_pins.tdi}),
        .level   (pin_level),
        .rise    (pin_rise)
    );

    assign tck_rise   = pin_rise[2];
    assign tms_lvl    = pin_level[1];
    assign tdi_lvl    = pin_level[0];
    assign chip_rst   = pin_level[3]; // synced active high, so idle after a bus reset
    assign loaded_lvl = pin_level[4];
    assign term_lvl   = pin_level[5];

    // port enable and abort conditions
    assign port_on  = dedic_reg | (~chip_rst & (enable_reg | term_lvl));
    assign abort    = chip_rst & ~dedic_reg;
    assign execute  = port_active & tck_rise & tms_lvl & loaded_reg;
    assign cmd_op   = shift_reg[OP_LSB +: 4];
    assign cmd_addr = shift_reg[ADDR_LSB +: ADDR_W];
    assign cmd_data = shift_reg[DATA_LSB +: DATA_W];
    assign allowed  = ~lock_reg | (cmd_op == OP_CHIP_ERASE) | (cmd_op == OP_CLEAR);
    assign prot_hit = protect_reg[sector_of(cmd_addr)];
    assign start_op = execute && state_reg == OPS_IDLE && allowed &&
                      (cmd_op == OP_PROGRAM || cmd_op == OP_CHIP_ERASE ||
                       (cmd_op == OP_SECTOR_ERASE && !prot_hit));
    assign finish   = state_reg == OPS_DONE;

    // nonvolatile bits captured once config load is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loaded_reg  <= 1'b0;
            lock_reg    <= 1'b0;
            dedic_reg   <= 1'b0;
            protect_reg <= '0;
        end else if (!loaded_reg && loaded_lvl) begin
            loaded_reg  <= 1'b1;
            lock_reg    <= nv_config.secure;
            dedic_reg   <= nv_config.dedicate;
            protect_reg <= nv_config.sector_protect;
        end else if (finish && op_reg == OP_CHIP_ERASE) begin
            lock_reg    <= 1'b0;
            protect_reg <= '0;
        end
    end

    // flash operation sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= OPS_IDLE;
            count_reg <= '0;
            op_reg    <= OP_NOP;
            addr_reg  <= '0;
            data_reg  <= '0;
        end else if (abort) begin
            state_reg <= OPS_IDLE;
            count_reg <= '0;
        end else begin
            unique case (state_reg)
                OPS_IDLE: begin
                    if (start_op) begin
                        state_reg <= OPS_BUSY;
                        op_reg    <= cmd_op;
                        addr_reg  <= cmd_addr;
                        data_reg  <= cmd_data;
                        count_reg <= 16'((cmd_op == OP_PROGRAM) ? PROGRAM_CYCLES - 1
                                                                : ERASE_CYCLES - 1);
                    end
                end
                OPS_BUSY: begin
                    if (count_reg == '0) state_reg <= OPS_DONE;
                    else count_reg <= count_reg - 16'h0001;
                end
                OPS_DONE: state_reg <= OPS_IDLE;
                default:  state_reg <= OPS_IDLE;
            endcase
        end
    end

    flash_image u_flash (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .prog_en       (finish && op_reg == OP_PROGRAM),
        .sect_erase_en (finish && op_reg == OP_SECTOR_ERASE),
        .chip_erase_en (finish && op_reg == OP_CHIP_ERASE),
        .addr          ((state_reg == OPS_IDLE) ? cmd_addr : addr_reg),
        .wdata         (data_reg),
        .rdata         (flash_rdata)
    );

    // shift chain; read results load into it on execute
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg <= '0;
            tdo_out   <= 1'b0;
        end else if (abort) begin
            shift_reg <= '0;
        end else if (execute) begin
            if (cmd_op == OP_READ && state_reg == OPS_IDLE)
                shift_reg <= lock_reg ? '0 : CMD_W'(flash_rdata);
            else
                shift_reg <= '0;
        end else if (port_active && tck_rise) begin
            tdo_out   <= shift_reg[CMD_W-1];
            shift_reg <= {shift_reg[CMD_W-2:0], tdi_lvl};
        end
    end

    // error flag: set by refused or failed commands, set beats clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_reg <= 1'b0;
        end else if (execute && (!allowed || state_reg != OPS_IDLE ||
                     (cmd_op == OP_SECTOR_ERASE && prot_hit) ||
                     (cmd_op == OP_VERIFY && flash_rdata != cmd_data))) begin
            err_reg <= 1'b1;
        end else if ((execute && cmd_op == OP_CLEAR) || abort) begin
            err_reg <= 1'b0;
        end
    end

    // pin-side outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_active         <= 1'b0;
            tdo_oe_n            <= 1'b1;
            program_status_out  <= 1'b1;
            program_error_out_n <= 1'b1;
        end else begin
            port_active         <= port_on;
            tdo_oe_n            <= ~port_on;
            program_status_out  <= (state_reg == OPS_IDLE) && !start_op;
            program_error_out_n <= ~err_reg;
        end
    end

    // bus address phase: capture writes, prepare read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            hrdata      <= '0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready) begin
                wr_pend_reg <= hsel && htrans == HTRANS_NONSEQ && hwrite;
                wr_addr_reg <= haddr;
                hrdata      <= '0;
                if (hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
                    unique case (haddr)
                        PORT_ENABLE_OFS: hrdata <= {31'h0, enable_reg};
                        STATUS_OFS:      hrdata <= {26'h0, loaded_reg, dedic_reg,
                                                    err_reg, state_reg != OPS_IDLE,
                                                    port_active, lock_reg};
                        CONFIG_OFS:      hrdata <= {24'h0, config_reg};
                        default:         hrdata <= '0;
                    endcase
                end
            end
        end
    end

    // run-time enable bit; bits 7:1 are not stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_reg <= PORT_ENABLE_RST[ENABLE_BIT];
        end else if (chip_rst) begin
            enable_reg <= 1'b0;
        end else if (wr_pend_reg && wr_addr_reg == PORT_ENABLE_OFS) begin
            enable_reg <= hwdata[ENABLE_BIT];
        end
    end

    // configuration byte, zero in delivered state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            config_reg <= CONFIG_RST;
        end else if (wr_pend_reg && wr_addr_reg == CONFIG_OFS) begin
            config_reg <= hwdata[7:0];
        end
    end

    sequence chip_erase_done_s;
        finish && op_reg == OP_CHIP_ERASE;
    endsequence

    sequence locked_cmd_s;
        execute && lock_reg && cmd_op != OP_CHIP_ERASE && cmd_op != OP_CLEAR;
    endsequence

    lock_read_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
        execute && lock_reg && cmd_op == OP_READ |=> shift_reg == '0)
        else $error("readout leaked while locked");

    lock_erase_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
        start_op && lock_reg |-> cmd_op == OP_CHIP_ERASE)
        else $error("locked port started a non-erase operation");

    lock_cmd_refused_a: assert property (@(posedge hclk) disable iff (!hresetn)
        locked_cmd_s |=> state_reg == OPS_IDLE && err_reg)
        else $error("locked command not refused");

    erase_unlocks_a: assert property (@(posedge hclk) disable iff (!hresetn)
        chip_erase_done_s ##1 !abort |-> !lock_reg && protect_reg == '0)
        else $error("chip erase did not clear lock");

    protect_blocks_a: assert property (@(posedge hclk) disable iff (!hresetn)
        execute && cmd_op == OP_SECTOR_ERASE && prot_hit |-> !start_op ##1 err_reg)
        else $error("protected sector erase accepted");

    config_reset_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> config_reg == CONFIG_RST)
        else $error("configuration not zero after reset");

    enable_follows_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_reg && wr_addr_reg == PORT_ENABLE_OFS && !chip_rst && !dedic_reg
        && !term_lvl ##1 !chip_rst && !term_lvl |=> port_active == $past(hwdata[ENABLE_BIT], 2))
        else $error("port does not follow enable bit");

    dedic_survives_a: assert property (@(posedge hclk) disable iff (!hresetn)
        dedic_reg && chip_rst |=> port_active
        && ($past(state_reg) != OPS_BUSY || state_reg != OPS_IDLE))
        else $error("chip reset disturbed dedicated port");

    reset_aborts_a: assert property (@(posedge hclk) disable iff (!hresetn)
        abort [*2] |-> !enable_reg && state_reg == OPS_IDLE ##1 !port_active || term_lvl)
        else $error("chip reset did not stop register-enabled port");
endmodule

// [tb/jtag_host_model.sv]
// Purpose: behavioural serial test controller driving the test pins
// Assumes: tck idles low between frames, 160 ns period
// Notes:   tdo sampled late in each high phase of tck
`timescale 1ns/100ps
module jtag_host_model (
    output isp_sec_pkg::test_pins_t pins,
    input  wire logic               tdo
);
    import isp_sec_pkg::*;

    // clock low, tdi parked high until the first frame
    initial pins = 3'b001;

    // one tck period; tdi flips after the rise so it never looks held
    task automatic pulse(input logic ms, input logic di, output logic seen);
        pins.tms = ms;
        pins.tdi = di;
        #80 pins.tck = 1'b1;
        #79 seen = tdo;
        pins.tdi = ~di;
        #1 pins.tck = 1'b0;
    endtask

    // 24 shift rises msb first, then one run rise with tms high
    task automatic run_frame(input logic [CMD_W-1:0] frame, output logic [CMD_W-1:0] got);
        logic seen;
        #3;
        for (int i = CMD_W - 1; i >= 0; i--) begin
            pulse(1'b0, frame[i], seen);
            got = {got[CMD_W-2:0], seen};
        end
        pulse(1'b1, 1'b0, seen);
    endtask
endmodule

// [tb/jtag_isp_security_control_tb.sv]
// Purpose: self-checking bench for the test-port security block
// Assumes: host model owns the serial pins, bench owns the bus
// Notes:   random data from a fixed seed, corner cases by hand
`timescale 1ns/100ps
module jtag_isp_security_control_tb;
    import isp_sec_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        chip_reset_n = 1'b1;
    logic        config_loaded = 1'b0;
    nv_config_t  nv = '0;
    logic        term = 1'b0;
    logic        hreadyout, hresp, tdo_out, tdo_oe_n, busy_n, err_n, port_active;
    logic        busy_seen;
    logic [31:0] hrdata, rd;
    logic [23:0] sh;
    logic [7:0]  d;
    logic [5:0]  a;
    test_pins_t  pins;
    int          fail_count = 0;
    int          total_checks = 0;
    logic [3:0]  ops [4] = '{OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_VERIFY};

    always #5 hclk = ~hclk;

    jtag_isp_security_control i_jtag_isp_security_control (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .test_pins(pins),
        .chip_reset_n(chip_reset_n), .config_loaded(config_loaded), .nv_config(nv),
        .pin_enable_product_term(term), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n),
        .program_status_out(busy_n), .program_error_out_n(err_n), .port_active(port_active));

    jtag_host_model i_jtag_host_model (.pins(pins), .tdo(tdo_out));

    // comparisons, one per kind of result
    task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp, input string m);
        check32({31'h0, got}, {31'h0, exp}, m);
    endtask
    // expected status word, fields placed by the package positions
    function automatic logic [31:0] status_exp(input logic ld, input logic pt, input logic lk);
        status_exp            = 32'h0;
        status_exp[SB_LOADED] = ld;
        status_exp[SB_PORT]   = pt;
        status_exp[SB_LOCK]   = lk;
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // bus helpers: wait for hready, address phase then data phase
    task automatic wait_rdy();
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask
    task automatic xfer(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= ad;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic reg_check(input logic [11:0] ad, input logic [31:0] exp, input string m);
        xfer(1'b0, ad, 32'h0);
        check32(rd, exp, m);
        check_bit(hresp, 1'b0, "bus response");
    endtask

    // serial command, then wait for the flash to report ready
    task automatic port_op(input logic [3:0] op, input logic [5:0] ad, input logic [7:0] dv);
        i_jtag_host_model.run_frame({op, 6'h00, ad, dv}, sh);
        @(posedge hclk);
        busy_seen = busy_n;
        while (busy_n !== 1'b1) @(posedge hclk);
        @(posedge hclk);
    endtask
    task automatic port_read(input logic [5:0] ad, input logic [7:0] exp, input string m);
        port_op(OP_READ, ad, 8'h00);
        port_op(OP_NOP, 6'h00, 8'h00);
        check32({8'h00, sh}, {24'h0, exp}, m);
    endtask
    task automatic start(input nv_config_t cfg);
        hresetn       <= 1'b0;
        config_loaded <= 1'b0;
        nv            <= cfg;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask
    task automatic load();
        config_loaded <= 1'b1;
        repeat (8) @(posedge hclk);
    endtask

    // watchdog well beyond the expected run length
    initial begin
        #600000;
        fail_count++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'hCA8A));
        // locked part: delivered register values, lock seen only after load
        start('{secure: 1'b1, dedicate: 1'b0, sector_protect: 12'h004});
        check_bit(hreadyout, 1'b1, "ready in reset");
        check_bit(tdo_oe_n, 1'b1, "tdo released");
        reg_check(CONFIG_OFS, 32'h0, "config delivered");
        reg_check(PORT_ENABLE_OFS, 32'h0, "enable at reset");
        reg_check(STATUS_OFS, status_exp(1'b0, 1'b0, 1'b0), "status before load");
        load();
        reg_check(STATUS_OFS, status_exp(1'b1, 1'b0, 1'b1), "status locked");
        d = 8'($urandom());
        xfer(1'b1, CONFIG_OFS, {24'h0, d});
        reg_check(CONFIG_OFS, {24'h0, d}, "config readback");
        xfer(1'b1, 12'h100, 32'($urandom()));
        reg_check(12'h100, 32'h0, "unmapped read");
        xfer(1'b1, PORT_ENABLE_OFS, 32'h0000_0001);
        reg_check(PORT_ENABLE_OFS, 32'h1, "enable readback");
        check_bit(port_active, 1'b1, "port on");
        check_bit(tdo_oe_n, 1'b0, "tdo driven");
        a = 6'($urandom_range(47));
        port_read(a, 8'h00, "locked readout");
        foreach (ops[i]) begin
            port_op(ops[i], a, 8'h00);
            check_bit(err_n, 1'b0, "locked op refused");
            port_op(OP_CLEAR, 6'h00, 8'h00);
            check_bit(err_n, 1'b1, "error cleared");
        end
        port_op(OP_CHIP_ERASE, 6'h00, 8'h00);
        check_bit(busy_seen, 1'b0, "chip erase runs");
        check_bit(err_n, 1'b1, "chip erase allowed");
        reg_check(STATUS_OFS, status_exp(1'b1, 1'b1, 1'b0), "lock cleared");
        port_read(a, ERASED_BYTE, "blank after erase");
        d = 8'($urandom());
        port_op(OP_PROGRAM, a, d);
        port_read(a, d, "program unlocked");
        xfer(1'b1, PORT_ENABLE_OFS, 32'h0);
        repeat (2) @(posedge hclk);
        check_bit(port_active, 1'b0, "port off");
        // open part: product term, protection, abort by chip reset
        start('{secure: 1'b0, dedicate: 1'b0, sector_protect: 12'h004});
        load();
        term <= 1'b1;
        repeat (6) @(posedge hclk);
        check_bit(port_active, 1'b1, "term enables port");
        port_read(6'($urandom_range(47)), ERASED_BYTE, "delivered memory");
        d = 8'($urandom());
        port_op(OP_PROGRAM, 6'd9, d);
        port_op(OP_VERIFY, 6'd9, d);
        check_bit(err_n, 1'b1, "verify match");
        port_op(OP_VERIFY, 6'd9, ~d);
        check_bit(err_n, 1'b0, "verify mismatch");
        port_op(OP_CLEAR, 6'h00, 8'h00);
        port_op(OP_SECTOR_ERASE, 6'd9, 8'h00);
        check_bit(err_n, 1'b0, "protected erase");
        port_read(6'd9, d, "protected kept");
        port_op(OP_CLEAR, 6'h00, 8'h00);
        port_op(OP_PROGRAM, 6'd5, 8'h00);
        port_op(OP_SECTOR_ERASE, 6'd5, 8'h00);
        port_read(6'd5, ERASED_BYTE, "sector erased");
        term <= 1'b0;
        xfer(1'b1, PORT_ENABLE_OFS, 32'h1);
        i_jtag_host_model.run_frame({OP_CHIP_ERASE, 20'h0}, sh);
        @(posedge hclk);
        chip_reset_n <= 1'b0;
        repeat (8) @(posedge hclk);
        check_bit(port_active, 1'b0, "reset stops port");
        check_bit(busy_n, 1'b1, "erase aborted");
        chip_reset_n <= 1'b1;
        reg_check(PORT_ENABLE_OFS, 32'h0, "reset clears enable");
        check_bit(port_active, 1'b0, "port stays off");
        // dedicated pins ignore chip reset
        start('{secure: 1'b0, dedicate: 1'b1, sector_protect: 12'h000});
        load();
        chip_reset_n <= 1'b0;
        repeat (8) @(posedge hclk);
        check_bit(port_active, 1'b1, "dedicated port");
        d = 8'($urandom());
        port_op(OP_PROGRAM, 6'd40, d);
        port_read(6'd40, d, "ops during reset");
        chip_reset_n <= 1'b1;
        give_verdict();
    end
endmodule
